// ==== sim/fsl_indicator_test.sv ====
// Purpose: Self-checking bench for the status LED indicator
// Assumes: One ms is MS cycles; inputs change at the falling edge
// Notes:   LED timings are judged by the operator model
`timescale 1ns/100ps
`default_nettype none
module fsl_indicator_test
  import fsl_pkg::*;
;
  // ==========================================================
  // Clock, design and operator
  // ==========================================================
  localparam int MS = 2;
  localparam int TOL = 6;
  localparam int GR = 0, RD = 1, PG = 2, AL = 3, BL = 4, YE = 5;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clr = 1'b0;
  logic feed = 1'b0;
  logic pulse = 1'b0;
  fsl_tx_in_t tx_in = '0;
  fsl_rx_in_t rx_set = '0;
  fsl_rx_in_t rx_in;
  logic tx_led_green, tx_led_red, tx_beeper, tx_power_off;
  fsl_rx_led_t rx_led;
  int op_pulses [6];
  int op_on [6];
  int op_grp [6];
  int fails = 0, total_checks = 0, cycles = 0, win_q = 0, gap = 0;
  int seed = 71;
  int rnd;
  int n_tab [6] = '{1, 1, 1, 2, 3, 4};
  int on_tab [6] = '{1000, 2000, 2000, 250, 250, 250};

  always #10 mclk = ~mclk;

  // Transfer edges merge into the condition flags
  always_comb begin
    rx_in = rx_set;
    rx_in.data_pulse = pulse;
  end

  fsl_indicator #(.MS_CYCLES(MS)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .tx_in(tx_in), .rx_in(rx_in),
    .tx_led_green(tx_led_green), .tx_led_red(tx_led_red),
    .tx_beeper(tx_beeper), .tx_power_off(tx_power_off), .rx_led(rx_led)
  );

  fsl_operator #(.LONG(375 * MS)) u_op (
    .mclk(mclk), .clr(clr),
    .led({rx_led.setup_yellow, rx_led.status_blue, rx_led.alarm_red,
          rx_led.power_green, tx_led_red, tx_led_green}),
    .pulses(op_pulses), .on_max(op_on), .grp(op_grp)
  );

  // ==========================================================
  // Model and compare tasks
  // ==========================================================
  function automatic int cyc(input int ms);
    return ms * MS;
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: level %b", $time, got);
    end
  endtask

  task automatic chk_len(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("unexpected at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask

  // Pattern kinds: 0 off, 1 steady, 2 slow, 3 fast, 4+n code of n
  task automatic pat(input int i, input int k);
    int on_exp;
    on_exp = (k == 0) ? 0 : (k == 1) ? win_q : (k == 2) ? cyc(500) :
             (k == 3) ? cyc(125) : cyc(250);
    chk_len(op_on[i], on_exp, TOL);
    if (k == 1) chk_len(op_pulses[i], 0, 0);
    if (k > 3) chk_len(op_grp[i], k - 4, 0);
  endtask

  task automatic watch(input int n);
    @(negedge mclk);
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    win_q = n;
    repeat (n) @(negedge mclk);
  endtask

  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Beeper must track the red LED on every cycle
  always @(negedge mclk) begin
    if (arst_n) chk_bit(tx_beeper, tx_led_red);
  end

  // Transfers at random spacing, well inside the gap limit
  always @(negedge mclk) begin
    if (gap > 0) gap <= gap - 1;
    else if (feed) begin
      pulse <= ~pulse;
      gap <= cyc(5) + ({$random(seed)} % cyc(40));
    end
  end

  // Cut a hang short; the full run needs about 70000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    // Failing power-on checks: stop, id, fault, on/off, battery, joystick
    for (int k = 0; k < 6; k++) begin
      tx_in = '0;
      tx_in[6 - k] = 1'b1;
      repeat (4) @(negedge mclk);
      tx_in.key_on = 1'b1;
      watch(cyc(n_tab[k] * (on_tab[k] + 250) + 400));
      chk_len(op_pulses[RD], n_tab[k], 0);
      chk_len(op_on[RD], cyc(on_tab[k]), TOL);
      chk_bit(tx_power_off, 1'b1);
      pat(GR, 0);
      tx_in = '0;
      repeat (10) @(negedge mclk);
      chk_bit(tx_power_off, 1'b0);
    end
    // Passing diagnosis, then start and link, then low battery in run
    tx_in.key_on = 1'b1;
    watch(cyc(1000));
    pat(GR, 3);
    pat(RD, 0);
    tx_in.start_btn = 1'b1;
    tx_in.link_up = 1'b1;
    repeat (cyc(50)) @(negedge mclk);
    tx_in.start_btn = 1'b0;
    watch(cyc(2250));
    pat(GR, 2);
    pat(RD, 0);
    tx_in.batt_low = 1'b1;
    repeat (10) @(negedge mclk);
    watch(cyc(2250));
    pat(RD, 2);
    pat(GR, 0);
    // Link lost in run falls back to rapid green
    tx_in.batt_low = 1'b0;
    tx_in.link_up = 1'b0;
    watch(cyc(1000));
    pat(GR, 3);
    // Start held at key-on skips diagnosis, so stop gives no red
    tx_in = '0;
    repeat (10) @(negedge mclk);
    tx_in.start_btn = 1'b1;
    tx_in.stop_btn = 1'b1;
    tx_in.key_on = 1'b1;
    watch(cyc(1000));
    pat(RD, 0);
    pat(GR, 3);
    tx_in = '0;
    // Unpowered receiver ignores every flag
    repeat (8) begin
      rnd = $random(seed);
      rx_set = fsl_rx_in_t'(rnd[11:0]);
      rx_set.powered = 1'b0;
      repeat (20) @(negedge mclk);
      chk_bit(|rx_led, 1'b0);
    end
    rx_set = '0;
    rx_set.powered = 1'b1;
    // Steady checks need the LED settled before the window opens
    repeat (10) @(negedge mclk);
    watch(cyc(1000));
    pat(PG, 1);
    pat(BL, 0);
    pat(AL, 0);
    pat(YE, 0);
    rx_set.link_up = 1'b1;
    feed = 1'b1;
    repeat (cyc(100)) @(negedge mclk);
    watch(cyc(2250));
    pat(PG, 2);
    pat(BL, 3);
    pat(AL, 0);
    pat(YE, 0);
    feed = 1'b0;
    repeat (cyc(450)) @(negedge mclk);
    watch(cyc(500));
    pat(BL, 0);
    feed = 1'b1;
    // Coded alarm and setup patterns
    rx_set.stop_out_err = 1'b1;
    rx_set.mem_err = 1'b1;
    watch(cyc(3300));
    pat(AL, 5);
    pat(YE, 6);
    rx_set.stop_out_err = 1'b0;
    rx_set.mem_err = 1'b0;
    rx_set.safety_out_err = 1'b1;
    rx_set.addr_key_err = 1'b1;
    watch(cyc(3300));
    pat(AL, 6);
    pat(YE, 5);
    // Stacked conditions keep one pattern per LED
    rx_set.addr_key_err = 1'b0;
    rx_set.rx_fault = 1'b1;
    rx_set.overcurrent = 1'b1;
    rx_set.overvolt = 1'b1;
    rx_set.setup_mode = 1'b1;
    repeat (10) @(negedge mclk);
    watch(cyc(1000));
    pat(AL, 1);
    pat(BL, 1);
    pat(YE, 1);
    rx_set.overcurrent = 1'b0;
    rx_set.setup_multi = 1'b1;
    watch(cyc(2250));
    pat(BL, 2);
    pat(YE, 3);
    // Reset in mid-run clears every output
    arst_n = 1'b0;
    @(negedge mclk);
    chk_bit(|{rx_led, tx_led_green, tx_led_red}, 1'b0);
    chk_bit(tx_power_off, 1'b0);
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    // Flags still set reach the LEDs only after the synchronisers refill
    repeat (2) @(negedge mclk);
    chk_bit(|rx_led, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire

// ==== sim/fsl_operator.sv ====
// Purpose: Operator who watches the LEDs and times every flash
// Assumes: LEDs sampled on mclk; clr restarts all counts
// Notes:   A dark gap over LONG cycles closes one flash group
`timescale 1ns/100ps
`default_nettype none
module fsl_operator #(
  parameter int LONG = 750
)(
  input wire logic mclk,
  input wire logic clr,
  input wire logic [5:0] led,
  output var int pulses [6],
  output var int on_max [6],
  output var int grp [6]
);
  // ==========================================================
  // Per-LED timing
  // ==========================================================
  int on_run [6];
  int off_run [6];
  int cur [6];
  logic [5:0] led_p = '0;
  // First group after clr may be partial; grp takes every closed group, so only a second gap gives a full count
  always @(posedge mclk) begin
    for (int i = 0; i < 6; i++) begin
      if (clr) begin
        pulses[i] = 0;
        on_max[i] = 0;
        on_run[i] = 0;
        off_run[i] = 0;
        cur[i] = 0;
        grp[i] = 0;
      end else if (led[i]) begin
        if (!led_p[i]) begin
          pulses[i]++;
          if (off_run[i] > LONG) begin
            grp[i] = cur[i];
            cur[i] = 0;
          end
          cur[i]++;
        end
        off_run[i] = 0;
        on_run[i]++;
        if (on_run[i] > on_max[i]) on_max[i] = on_run[i];
      end else begin
        on_run[i] = 0;
        off_run[i]++;
      end
    end
    led_p = led;
  end
endmodule
`default_nettype wire

// ==== verilog/fsl_coder.sv ====
// Purpose: Repeating n-flash-plus-pause code generator
// Assumes: code_tick comes from the shared timebase, one cycle wide
// Notes:   Restarts cleanly whenever the requested count changes
`timescale 1ns/100ps
`default_nettype none
module fsl_coder
  import fsl_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic code_tick,
  input wire logic [2:0] flashes,
  output logic led
);

  typedef struct packed {
    logic [2:0] req;
    logic [3:0] phase;
    logic led;
  } fsl_coder_st_t;

  fsl_coder_st_t st_q, st_d;

  // ==========================================================
  // Phase walk: even phases light, odd dark, then one pause
  // ==========================================================
  always_comb begin
    st_d = st_q;
    st_d.req = flashes;
    if (flashes != st_q.req) begin
      st_d.phase = '0;
      st_d.led = 1'b0;
    end else if (code_tick) begin
      if (flashes == 3'h0) begin
        st_d.phase = '0;
        st_d.led = 1'b0;
      end else begin
        // Pause occupies two extra half periods after the last flash
        if (st_q.phase >= {flashes, 1'b0} + {1'b0, FSL_CNT_PAUSE})
          st_d.phase = '0;
        else
          st_d.phase = st_q.phase + 4'h1;
        st_d.led = (st_d.phase < {flashes, 1'b0}) && !st_d.phase[0];
      end
    end
  end

  // Pattern state restarts on reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign led = st_q.led;

endmodule
`default_nettype wire

// ==== verilog/fsl_indicator.sv ====
// Purpose: Transmitter self-diagnosis and receiver LED fault indication
// Assumes: Condition inputs are asynchronous to mclk and are synchronised
// Notes:   Power-off is a request level; the supply logic acts on it
`timescale 1ns/100ps
`default_nettype none
module fsl_indicator
  import fsl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = FSL_MS_CYCLES
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire fsl_tx_in_t tx_in,
  input wire fsl_rx_in_t rx_in,
  output logic tx_led_green,
  output logic tx_led_red,
  output logic tx_beeper,
  output logic tx_power_off,
  output fsl_rx_led_t rx_led
);

  typedef enum {TX_IDLE, TX_DIAG, TX_PASS, TX_RUN, TX_RED_ON, TX_CODE,
    TX_OFF} fsl_tx_state_t;

  typedef struct packed {
    fsl_tx_in_t tx_s1;
    fsl_tx_in_t tx_s2;
    fsl_rx_in_t rx_s1;
    fsl_rx_in_t rx_s2;
    logic key_prev;
    logic data_prev;
    logic [15:0] pre;
    logic [9:0] ms;
    fsl_tick_t tick;
    logic slow_ph;
    logic fast_ph;
    fsl_tx_state_t tx_st;
    logic [11:0] hold;
    logic [2:0] code_left;
    logic code_on;
    logic [9:0] gap;
    logic green;
    logic red;
    logic off;
    fsl_rx_led_t led;
  } fsl_ind_st_t;

  fsl_ind_st_t st_q, st_d;
  logic alarm_code;
  logic setup_code;
  logic [2:0] alarm_n;
  logic [2:0] setup_n;

  // Half period of a named time minus one, in ms ticks
  function automatic logic [9:0] half_ms(input int unsigned period);
    half_ms = 10'((period / 2) - 1);
  endfunction

  // ==========================================================
  // Coded flash generators for alarm and setup LEDs
  // ==========================================================
  always_comb begin
    // Stop error outranks safety error
    if (st_q.rx_s2.stop_out_err)
      alarm_n = FSL_CNT_ONE;
    else if (st_q.rx_s2.safety_out_err)
      alarm_n = FSL_CNT_TWO;
    else
      alarm_n = 3'h0;
    if (st_q.rx_s2.addr_key_err)
      setup_n = FSL_CNT_ONE;
    else if (st_q.rx_s2.mem_err)
      setup_n = FSL_CNT_TWO;
    else
      setup_n = 3'h0;
  end

  fsl_coder u_alarm (
    .mclk(mclk),
    .arst_n(arst_n),
    .code_tick(st_q.tick.code),
    .flashes(alarm_n),
    .led(alarm_code)
  );

  fsl_coder u_setup (
    .mclk(mclk),
    .arst_n(arst_n),
    .code_tick(st_q.tick.code),
    .flashes(setup_n),
    .led(setup_code)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_d = st_q;
    // Two-stage synchronisers; only stage two is read by logic
    st_d.tx_s1 = tx_in;
    st_d.tx_s2 = st_q.tx_s1;
    st_d.rx_s1 = rx_in;
    st_d.rx_s2 = st_q.rx_s1;
    st_d.key_prev = st_q.tx_s2.key_on;
    st_d.data_prev = st_q.rx_s2.data_pulse;

    // Free-running timebase: ms tick, then derived periods
    st_d.tick = '0;
    if (st_q.pre >= 16'(MS_CYCLES - 1)) begin
      st_d.pre = '0;
      st_d.tick.ms = 1'b1;
      st_d.ms = (st_q.ms >= 10'(FSL_SLOW_PERIOD_MS - 1)) ? '0 :
        st_q.ms + 10'h1;
    end else begin
      st_d.pre = st_q.pre + 16'h1;
    end
    if (st_q.tick.ms) begin
      if (st_q.ms == '0 || st_q.ms == half_ms(FSL_SLOW_PERIOD_MS) + 10'h1)
        st_d.slow_ph = (st_q.ms == '0);
      if (st_q.ms % 10'(FSL_FAST_PERIOD_MS / 2) == '0)
        st_d.fast_ph = !st_q.fast_ph;
      st_d.tick.code = (st_q.ms % 10'(FSL_CODE_PERIOD_MS / 2) == '0);
      st_d.tick.slow = (st_q.ms == '0);
      st_d.tick.fast = (st_q.ms % 10'(FSL_FAST_PERIOD_MS / 2) == '0);
    end

    // -------------------- Transmitter sequence --------------------
    st_d.green = 1'b0;
    st_d.red = 1'b0;
    case (st_q.tx_st)
      TX_IDLE: begin
        if (st_q.tx_s2.key_on && !st_q.key_prev) begin
          if (st_q.tx_s2.start_btn)
            st_d.tx_st = TX_PASS;
          else
            st_d.tx_st = TX_DIAG;
        end
      end
      TX_DIAG: begin
        st_d.hold = '0;
        st_d.code_on = 1'b0;
        if (st_q.tx_s2.stop_btn) begin
          st_d.hold = 12'(FSL_STOP_ON_MS);
          st_d.tx_st = TX_RED_ON;
        end else if (st_q.tx_s2.id_missing || st_q.tx_s2.tx_fault) begin
          st_d.hold = 12'(FSL_FAIL_ON_MS);
          st_d.tx_st = TX_RED_ON;
        end else if (st_q.tx_s2.onoff_active) begin
          st_d.code_left = FSL_CNT_ONOFF;
          st_d.tx_st = TX_CODE;
        end else if (st_q.tx_s2.batt_low) begin
          st_d.code_left = FSL_CNT_LOWBAT;
          st_d.tx_st = TX_CODE;
        end else if (st_q.tx_s2.joy_off_zero) begin
          st_d.code_left = FSL_CNT_JOY;
          st_d.tx_st = TX_CODE;
        end else begin
          st_d.tx_st = TX_PASS;
        end
      end
      TX_PASS: begin
        st_d.green = st_q.fast_ph;
        if (st_q.tx_s2.link_up)
          st_d.tx_st = TX_RUN;
      end
      TX_RUN: begin
        // Slow flash colour follows battery state
        st_d.green = st_q.slow_ph && !st_q.tx_s2.batt_low;
        st_d.red = st_q.slow_ph && st_q.tx_s2.batt_low;
        if (!st_q.tx_s2.link_up)
          st_d.tx_st = TX_PASS;
      end
      TX_RED_ON: begin
        st_d.red = 1'b1;
        if (st_q.tick.ms) begin
          if (st_q.hold <= 12'h1)
            st_d.tx_st = TX_OFF;
          else
            st_d.hold = st_q.hold - 12'h1;
        end
      end
      TX_CODE: begin
        st_d.red = st_q.code_on;
        if (st_q.tick.code) begin
          if (st_q.code_on) begin
            st_d.code_on = 1'b0;
            st_d.code_left = st_q.code_left - 3'h1;
            if (st_q.code_left == FSL_CNT_ONE)
              st_d.tx_st = TX_OFF;
          end else begin
            st_d.code_on = 1'b1;
          end
        end
      end
      TX_OFF: begin
        st_d.off = 1'b1;
      end
      default: begin
        st_d.tx_st = TX_IDLE;
      end
    endcase
    // Key back to 0 always ends the session
    if (!st_q.tx_s2.key_on) begin
      st_d.tx_st = TX_IDLE;
      st_d.off = 1'b0;
    end

    // -------------------- Receiver LEDs --------------------
    // Missing-transfer gap: rapid blue is blanked until data returns
    if (st_q.rx_s2.data_pulse && !st_q.data_prev)
      st_d.gap = 10'(FSL_GAP_MS);
    else if (st_q.tick.ms && st_q.gap != '0)
      st_d.gap = st_q.gap - 10'h1;

    st_d.led = '0;
    if (st_q.rx_s2.powered) begin
      // Steady green without link, slow green with it
      st_d.led.power_green = st_q.rx_s2.link_up ? st_q.slow_ph : 1'b1;
      // Internal failure outranks output codes
      if (st_q.rx_s2.rx_fault)
        st_d.led.alarm_red = 1'b1;
      else
        st_d.led.alarm_red = alarm_code;
      // Status priority: overcurrent, overvoltage, data
      if (st_q.rx_s2.overcurrent)
        st_d.led.status_blue = 1'b1;
      else if (st_q.rx_s2.overvolt)
        st_d.led.status_blue = st_q.slow_ph;
      else if (!st_q.rx_s2.link_up)
        st_d.led.status_blue = 1'b0;
      else
        st_d.led.status_blue = st_q.fast_ph && (st_q.gap != '0);
      // Errors outrank setup indication
      if (setup_n != 3'h0)
        st_d.led.setup_yellow = setup_code;
      else if (st_q.rx_s2.setup_mode)
        st_d.led.setup_yellow = st_q.rx_s2.setup_multi ? st_q.fast_ph :
          1'b1;
      else
        st_d.led.setup_yellow = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.tx_st <= TX_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs from flip-flops; beeper follows red exactly
  assign tx_led_green = st_q.green;
  assign tx_led_red = st_q.red;
  assign tx_beeper = st_q.red;
  assign tx_power_off = st_q.off;
  assign rx_led = st_q.led;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_stop_seen;
    st_q.tx_st == TX_DIAG && st_q.tx_s2.stop_btn && st_q.tx_s2.key_on;
  endsequence

  AST_BEEP_RED: assert property (
    @(posedge mclk) disable iff (!arst_n) tx_beeper == tx_led_red)
    else $error("beeper differs from red led");

  AST_STOP_RED: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_stop_seen |=> st_q.tx_st == TX_RED_ON ##1 tx_led_red)
    else $error("stop did not light red");

  AST_OFF_HOLD: assert property (
    @(posedge mclk) disable iff (!arst_n)
    tx_power_off && st_q.tx_s2.key_on |=> tx_power_off)
    else $error("power off released early");

  AST_OVERCUR: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.rx_s2.powered && st_q.rx_s2.overcurrent |=> rx_led.status_blue)
    else $error("overcurrent not steady blue");

  AST_NOLINK_GREEN: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.rx_s2.powered && !st_q.rx_s2.link_up |=> rx_led.power_green)
    else $error("no link green not steady");

  AST_NOLINK_BLUE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.rx_s2.powered && !st_q.rx_s2.link_up && !st_q.rx_s2.overvolt &&
    !st_q.rx_s2.overcurrent |=> !rx_led.status_blue)
    else $error("blue lit without link");

  AST_FAULT_ALARM: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.rx_s2.powered && st_q.rx_s2.rx_fault |=> rx_led.alarm_red)
    else $error("receiver fault not steady red");

  AST_SETUP_ON: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.rx_s2.powered && st_q.rx_s2.setup_mode && !st_q.rx_s2.setup_multi
    && setup_n == 3'h0 |=> rx_led.setup_yellow)
    else $error("setup not steady yellow");

  AST_GREEN_RUN: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.tx_st == TX_RUN && st_q.tx_s2.batt_low |=> !tx_led_green)
    else $error("green shown on low battery");

  // A passed diagnosis must never sound the beeper
  AST_PASS_DARK_RED: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_q.tx_st == TX_PASS |=> !tx_led_red)
    else $error("red lit after passed diagnosis");

endmodule
`default_nettype wire

// ==== verilog/fsl_pkg.sv ====
// Purpose: Shared constants and carrier types for the status LED indicator
// Assumes: 50 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`default_nettype none
package fsl_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned FSL_CLK_HZ = 50000000;
  localparam int unsigned FSL_SLOW_PERIOD_MS = 1000;
  localparam int unsigned FSL_FAST_PERIOD_MS = 250;
  localparam int unsigned FSL_CODE_PERIOD_MS = 500;
  localparam int unsigned FSL_STOP_ON_MS = 1000;
  localparam int unsigned FSL_FAIL_ON_MS = 2000;
  localparam int unsigned FSL_GAP_MS = 400;
  localparam int unsigned FSL_TICK_HZ = 1000;
  localparam int unsigned FSL_MS_CYCLES = FSL_CLK_HZ / FSL_TICK_HZ;

  // ==========================================================
  // Flash codes
  // ==========================================================
  localparam logic [2:0] FSL_CNT_ONOFF = 3'h2;
  localparam logic [2:0] FSL_CNT_LOWBAT = 3'h3;
  localparam logic [2:0] FSL_CNT_JOY = 3'h4;
  localparam logic [2:0] FSL_CNT_ONE = 3'h1;
  localparam logic [2:0] FSL_CNT_TWO = 3'h2;
  localparam logic [2:0] FSL_CNT_PAUSE = 3'h1;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic key_on;
    logic start_btn;
    logic stop_btn;
    logic id_missing;
    logic tx_fault;
    logic onoff_active;
    logic batt_low;
    logic joy_off_zero;
    logic link_up;
  } fsl_tx_in_t;

  typedef struct packed {
    logic powered;
    logic link_up;
    logic data_pulse;
    logic stop_out_err;
    logic safety_out_err;
    logic rx_fault;
    logic overvolt;
    logic overcurrent;
    logic addr_key_err;
    logic mem_err;
    logic setup_mode;
    logic setup_multi;
  } fsl_rx_in_t;

  typedef struct packed {
    logic power_green;
    logic alarm_red;
    logic status_blue;
    logic setup_yellow;
  } fsl_rx_led_t;

  typedef struct packed {
    logic slow;
    logic fast;
    logic code;
    logic ms;
  } fsl_tick_t;

endpackage
`default_nettype wire
